// ==== bench/fas_fans.sv ====
// three fans behind the drive outputs
// assumes duty on clk_i; speed settles toward duty one count a cycle
`timescale 1ns/10ps
module fas_fans (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0][7:0] duty_i,
  output logic [2:0][7:0] speed_o
);
  // rotor inertia: speed creeps toward drive
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      speed_o <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (speed_o[i] != duty_i[i]) begin
          speed_o[i] <= speed_o[i] + ((speed_o[i] < duty_i[i]) ? 8'h01 : 8'hFF);
        end
      end
    end
  end
endmodule

// ==== bench/fas_top_asserts.sv ====
// port-level assertions for fas_top, bound below
// assumes all ports on clk_i; shadows the control register from writes
`timescale 1ns/10ps
module fas_chk #(
  parameter int unsigned SLOT_CYC_LF [8] = fas_pkg::SLOT_CYC_LF,
  parameter int unsigned SLOT_CYC_HF [8] = fas_pkg::SLOT_CYC_HF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cfg_lock_i,
  input wire logic ramp_timing_sel_i,
  input wire fas_pkg::fas_drive_in_s [2:0] drive_i,
  input wire logic [2:0][7:0] fan_drive_duty_o,
  input wire logic [2:0] tach_sync_o
);
  logic [7:0] sh; // shadow of the control register
  logic [7:0] stp; // selected step
  logic [7:0] d0; // drive 0 duty
  logic [7:0] a0; // drive 0 target
  logic sm; // drive 0 under smoothing
  assign stp = fas_pkg::RAMP_STEP[sh[2:0]];
  assign d0 = fan_drive_duty_o[0];
  assign a0 = drive_i[0].auto_duty;
  assign sm = ce_i && drive_i[0].fan_behaviour_select == 3'h0 && sh[3];
  // shadow follows accepted writes only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh <= 8'h00;
    end else if (ce_i && reg_wr_i && !cfg_lock_i && reg_addr_i == 8'h62) begin
      sh <= reg_wdata_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd62;
    ce_i && reg_rd_i && reg_addr_i == 8'h62;
  endsequence
  a_read_back: assert property (s_rd62 |=> reg_rdata_o == $past(sh))
    else $error("register read back wrong");
  a_reset_zero: assert property ($rose(rstn_i) |-> d0 == 8'h00 && tach_sync_o == 3'b110)
    else $error("reset state wrong");
  a_tach_map: assert property ($past(ce_i) |-> tach_sync_o == {2'b11, $past(sh[4])})
    else $error("speed input sync wrong");
  a_smooth_off: assert property (
    sm == 1'b0 && ce_i && drive_i[0].fan_behaviour_select == 3'h0 && !sh[3]
    && !drive_i[0].below_start |=> d0 == $past(a0))
    else $error("unsmoothed duty wrong");
  a_step_bound: assert property (
    sm && !drive_i[0].below_start |=> ($past(d0) <= $past(a0)) ?
    (d0 >= $past(d0) && d0 <= $past(a0) && d0 - $past(d0) <= $past(stp)) :
    (d0 <= $past(d0) && d0 >= $past(a0) && $past(d0) - d0 <= $past(stp)))
    else $error("ramp step wrong");
  a_slot_gap: assert property (sm && $past(sm) && $changed(d0) |=> $stable(d0))
    else $error("duty changed in adjacent cycles");
  for (genvar i = 0; i < 3; i++) begin : g_drv
    a_floor_pick: assert property (
      ce_i && drive_i[i].below_start && drive_i[i].fan_behaviour_select == 3'h1
      |=> fan_drive_duty_o[i] == ($past(sh[5 + i]) ? $past(drive_i[i].min_duty) : 8'h00))
      else $error("floor duty wrong");
    a_manual_pass: assert property (
      ce_i && drive_i[i].fan_behaviour_select == 3'h7
      |=> fan_drive_duty_o[i] == $past(drive_i[i].auto_duty))
      else $error("manual duty wrong");
  end
endmodule
bind fas_top fas_chk #(.SLOT_CYC_LF(SLOT_CYC_LF), .SLOT_CYC_HF(SLOT_CYC_HF)) u_chk (
  .clk_i, .rstn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .cfg_lock_i, .ramp_timing_sel_i, .drive_i, .fan_drive_duty_o, .tach_sync_o);

// ==== bench/fas_top_bench.sv ====
// self-checking bench for fas_top through its register port
// assumes short slot lengths set here
`timescale 1ns/10ps
module fas_top_bench;
  localparam int unsigned LF [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
  localparam int unsigned HF [8] = '{12, 13, 14, 15, 16, 17, 18, 19};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cfg_lock_i = 1'b0;
  logic ramp_timing_sel_i = 1'b0;
  fas_pkg::fas_drive_in_s [2:0] drive_i = '0;
  logic [7:0] reg_rdata_o;
  logic [2:0][7:0] fan_drive_duty_o;
  logic [2:0] tach_sync_o;
  logic [2:0][7:0] fan_speed;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  fas_top #(.SLOT_CYC_LF(LF), .SLOT_CYC_HF(HF)) dut (.clk_i, .rstn_i, .ce_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cfg_lock_i, .ramp_timing_sel_i,
    .drive_i, .fan_drive_duty_o, .tach_sync_o);
  fas_fans u_fans (.clk_i, .rstn_i, .duty_i(fan_drive_duty_o), .speed_o(fan_speed));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data looked at in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e, "read data");
  endtask
  // ramp drive 0 from 0 to 3.5 steps, timing each step after the first
  task automatic ramp(input logic [2:0] c, input logic s);
    logic [7:0] st, t, e;
    int n, sl;
    st = fas_pkg::RAMP_STEP[c];
    t = 8'((int'(st) * 7) / 2);
    sl = s ? HF[c] : LF[c];
    e = 8'h00;
    drive_i[0] <= '{3'h7, 1'b0, 8'h00, 8'h00};
    ramp_timing_sel_i <= s;
    wr_reg(8'h62, {5'h01, c});
    drive_i[0] <= '{3'h0, 1'b0, t, 8'h00};
    for (int k = 0; e != t; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        #1 n++;
      end while (fan_drive_duty_o[0] === e && n < 100);
      e = (t - e > st) ? e + st : t;
      chk(fan_drive_duty_o[0], e, "ramp value");
      if (k > 0) chk(8'(n), 8'(sl), "slot length");
    end
    repeat (2 * sl) @(posedge clk_i);
    #1 chk(fan_drive_duty_o[0], t, "ramp end");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_reg(8'h62, 8'h00);
    chk({5'h00, tach_sync_o}, 8'h06, "sync after reset");
    wr_reg(8'h63, 8'h3C);
    rd_reg(8'h63, 8'h3C);
    rd_reg(8'h64, 8'h00);
    wr_reg(8'h62, 8'h10);
    @(posedge clk_i);
    #1 chk({5'h00, tach_sync_o}, 8'h07, "sync on");
    $display("register test done");
    for (int f = 5; f > 1; f -= 3) begin
      wr_reg(8'h62, {3'(f), 5'h00});
      for (int i = 0; i < 3; i++) begin
        drive_i[i] <= '{3'h1, 1'b1, 8'hF0, 8'(33 + i)};
      end
      repeat (2) @(posedge clk_i);
      for (int i = 0; i < 3; i++) begin
        #1 chk(fan_drive_duty_o[i], f[i] ? 8'(33 + i) : 8'h00, "floor");
      end
    end
    chk({5'h00, tach_sync_o}, 8'h06, "sync off");
    $display("floor test done");
    cfg_lock_i <= 1'b1;
    wr_reg(8'h62, 8'h00);
    wr_reg(8'h63, 8'h00);
    rd_reg(8'h62, 8'h40);
    rd_reg(8'h63, 8'h3C);
    cfg_lock_i <= 1'b0;
    drive_i[0] <= '{3'h0, 1'b0, 8'hC8, 8'h00};
    drive_i[1] <= '{3'h7, 1'b1, 8'h5A, 8'h11};
    drive_i[2] <= '{3'h7, 1'b1, 8'hA5, 8'h22};
    repeat (2) @(posedge clk_i);
    #1 chk(fan_drive_duty_o[0], 8'hC8, "no smoothing");
    chk(fan_drive_duty_o[1], 8'h5A, "manual no floor");
    chk(fan_drive_duty_o[2], 8'hA5, "manual no floor");
    $display("lock test done");
    ce_i <= 1'b0;
    wr_reg(8'h63, 8'h55);
    ce_i <= 1'b1;
    rd_reg(8'h63, 8'h3C);
    repeat (200) @(posedge clk_i);
    #1 chk(fan_speed[0], 8'hC8, "fan speed");
    $display("freeze test done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        ramp(3'(c), s[0]);
      end
    end
    $display("ramp test done");
    test_done();
  end
endmodule

// ==== core/fas_pkg.sv ====
// constants, field layout and carrier types of the fan acoustic smoothing block
// assumes a 50 MHz system clock and 8-bit register data

package fas_pkg;

  // system clock rate in kHz
  localparam int unsigned CLK_KHZ = 50000;

  // register offsets and values after reset
  localparam logic [7:0] REMOTE1_ACOUSTICS_CTRL_OFFSET = 8'h62;
  localparam logic [7:0] ACOUSTICS_CTRL_SECOND_OFFSET = 8'h63;
  localparam logic [7:0] REMOTE1_ACOUSTICS_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACOUSTICS_CTRL_SECOND_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [2:0] TACH_SYNC_RESET = 3'h6;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [31:0] SLOT_CNT_RESET = 32'h0;

  // field positions inside remote1_acoustics_ctrl
  localparam int unsigned RAMP_RATE_LSB = 0;
  localparam int unsigned SMOOTH_EN_BIT = 3;
  localparam int unsigned TACH_SYNC_BIT = 4;
  localparam int unsigned FLOOR_SEL_LSB = 5;

  // fan_behaviour_select codes
  localparam logic [2:0] BHV_REMOTE1 = 3'h0;
  localparam logic [2:0] BHV_LOCAL = 3'h1;
  localparam logic [2:0] BHV_REMOTE2 = 3'h2;
  localparam logic [2:0] BHV_FULL = 3'h3;
  localparam logic [2:0] BHV_OFF = 3'h4;
  localparam logic [2:0] BHV_FAST_LR2 = 3'h5;
  localparam logic [2:0] BHV_FAST_ALL = 3'h6;
  localparam logic [2:0] BHV_MANUAL = 3'h7;

  // duty change per time slot, by remote1_ramp_rate code
  localparam logic [7:0] RAMP_STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                           8'h08, 8'h0C, 8'h18, 8'h30};
  // full 0..100 % ramp time in ms, timing select low and high
  localparam int unsigned RAMP_MS_LF [8] = '{37500, 18800, 12500, 7500,
                                             4700, 3100, 1600, 800};
  localparam int unsigned RAMP_MS_HF [8] = '{52200, 26100, 17400, 10400,
                                             6500, 4400, 2200, 1100};
  // full-scale duty count
  localparam int unsigned DUTY_FULL = 255;

  // clock cycles per time slot: ramp time * step / full scale
  function automatic int unsigned slot_cycles(input int unsigned ms,
                                              input int unsigned step);
    longint unsigned cyc;
    cyc = longint'(ms) * longint'(CLK_KHZ) * longint'(step) / longint'(DUTY_FULL);
    if (cyc < 64'h1) begin
      cyc = 64'h1;
    end
    return int'(cyc[31:0]);
  endfunction

  // slot lengths for both timing selections
  localparam int unsigned SLOT_CYC_LF [8] = '{
    slot_cycles(RAMP_MS_LF[0], 1), slot_cycles(RAMP_MS_LF[1], 2),
    slot_cycles(RAMP_MS_LF[2], 3), slot_cycles(RAMP_MS_LF[3], 4),
    slot_cycles(RAMP_MS_LF[4], 8), slot_cycles(RAMP_MS_LF[5], 12),
    slot_cycles(RAMP_MS_LF[6], 24), slot_cycles(RAMP_MS_LF[7], 48)};
  localparam int unsigned SLOT_CYC_HF [8] = '{
    slot_cycles(RAMP_MS_HF[0], 1), slot_cycles(RAMP_MS_HF[1], 2),
    slot_cycles(RAMP_MS_HF[2], 3), slot_cycles(RAMP_MS_HF[3], 4),
    slot_cycles(RAMP_MS_HF[4], 8), slot_cycles(RAMP_MS_HF[5], 12),
    slot_cycles(RAMP_MS_HF[6], 24), slot_cycles(RAMP_MS_HF[7], 48)};

  // layout of remote1_acoustics_ctrl, msb first
  typedef struct packed {
    logic [2:0] floor_select;      // drive3, drive2, drive1
    logic tach_sync;
    logic remote1_smooth_enable;
    logic [2:0] remote1_ramp_rate;
  } fas_ctrl_s;

  // per-drive inputs from the automatic control path
  typedef struct packed {
    logic [2:0] fan_behaviour_select;
    logic below_start;             // temp below auto_start_temperature - hyst
    logic [7:0] auto_duty;         // newly computed duty
    logic [7:0] min_duty;          // programmed minimum duty
  } fas_drive_in_s;

endpackage

// ==== core/fas_top.sv ====
// remote-1 acoustic smoothing register and duty ramp for three fan drives
// assumes all inputs come from logic on clk_i; register port is a plain
// address/strobe port with read data one cycle after the read strobe
// assumes cfg_lock_i and ramp_timing_sel_i are held by configuration logic
// of the same clock domain, and that drive_i carries the duty already
// computed by the automatic control path for each drive

`timescale 1ns/10ps

module fas_top #(
  // slot lengths in cycles, shortenable for simulation
  parameter int unsigned SLOT_CYC_LF [8] = fas_pkg::SLOT_CYC_LF,
  parameter int unsigned SLOT_CYC_HF [8] = fas_pkg::SLOT_CYC_HF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic cfg_lock_i,
  input wire logic ramp_timing_sel_i,
  input wire fas_pkg::fas_drive_in_s [2:0] drive_i,
  output logic [2:0][7:0] fan_drive_duty_o,
  output logic [2:0] tach_sync_o
);

  // operation in brief:
  // - remote1_acoustics_ctrl holds the rate code, the smoothing enable,
  //   the speed-input sync bit and the three floor selects
  // - acoustics_ctrl_second is plain storage here; its fields steer the
  //   other channels' ramps, which live outside this block
  // - one free-running slot timer serves all three drives, so a target
  //   change waits at most one slot before its first step
  // - the slot length follows the rate code and the timing select; a
  //   change of either ends the slot at once if the count is already
  //   past the new length
  // - a smoothed drive moves by the selected step once per slot and
  //   stops on its target, rising and falling alike
  // - an unsmoothed drive follows its target one cycle after the inputs
  // - below the start temperature minus hysteresis an automatic drive
  //   takes 0% or its minimum duty, picked by its floor bit
  // - the floor is applied before ramping, so a smoothed drive also
  //   eases down onto its floor
  // - while ce_i is low every register, the timer and all outputs hold;
  //   only the reset synchroniser keeps running
  // - the lock input blocks every write; reads keep working
  //
  // register map on the plain port:
  // - 0x62 remote1_acoustics_ctrl: [2:0] rate code, [3] smoothing enable,
  //   [4] speed-input sync, [7:5] floor selects of drives 3, 2 and 1
  // - 0x63 acoustics_ctrl_second: stored and read back only
  // - any other address reads as zero and ignores writes
  //
  // outputs:
  // - fan_drive_duty_o[i] is the duty of drive i+1, 0 to 255
  // - tach_sync_o bits 0, 1 and 2 flag speed inputs 2, 3 and 4 as
  //   measured in step with drive 3
  // - reg_rdata_o carries read data for one cycle, zero otherwise
  //
  // limitations:
  // - only remote-1 smoothing is done here; the other channels' ramps
  //   belong to the logic that owns those channels
  // - the temperature compare is made upstream; below_start arrives
  //   as a ready flag per drive
  //
  // hazards:
  // - the slot timer is never cleared on a target change, trading an
  //   exact first-step delay for a single shared counter
  // - duty is an 8-bit count with 255 as full scale; the full-ramp
  //   times hold only for that scale

  // duty step for a rate code
  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    return fas_pkg::RAMP_STEP[code];
  endfunction

  // true for behaviour codes under automatic temperature control
  function automatic logic is_auto(input logic [2:0] bhv);
    logic r;
    r = 1'b0;
    case (bhv)
      fas_pkg::BHV_REMOTE1,
      fas_pkg::BHV_LOCAL,
      fas_pkg::BHV_REMOTE2,
      fas_pkg::BHV_FAST_LR2,
      fas_pkg::BHV_FAST_ALL: r = 1'b1;
      // full speed, off and manual are not automatic
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // one ramp slot toward target, clamped at target
  function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                             input logic [7:0] tgt,
                                             input logic [7:0] stp);
    logic [8:0] sum;
    logic [7:0] res;
    // ninth bit catches a carry past full scale
    sum = {1'b0, cur} + {1'b0, stp};
    res = cur;
    if (cur < tgt) begin
      // rising: stop at target
      res = (sum[7:0] > tgt || sum[8]) ? tgt : sum[7:0];
    end else if (cur > tgt) begin
      // falling: stop at target
      res = (cur - tgt < stp) ? tgt : cur - stp;
    end
    return res;
  endfunction

  // reset synchroniser stages
  logic rst_meta;
  logic rstn_sync;

  // register contents
  fas_pkg::fas_ctrl_s ctrl;
  logic [7:0] ctrl_second;

  // shared slot timer
  logic [31:0] slot_cnt;
  logic [31:0] slot_limit;
  logic slot_tick;

  // per-drive target duty after the floor choice
  logic [2:0][7:0] target;

  // write qualifiers
  logic wr_ok; // write strobe passed by the lock
  logic hit_ctrl; // remote1_acoustics_ctrl addressed
  logic hit_second; // acoustics_ctrl_second addressed

  // ramp controls: per-drive smoothing flags and one shared step
  logic [2:0] smooth_on; // drive i ramps instead of jumping
  logic [7:0] ramp_inc; // duty change per slot

  // release reset through two flops, assert immediately
  // both stages start low so no flop leaves reset ahead of the rest
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rstn_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rstn_sync <= rst_meta;
    end
  end

  // writes land only while the lock is clear
  assign wr_ok = reg_wr_i && !cfg_lock_i;

  // address decode used by both write paths
  assign hit_ctrl = (reg_addr_i == fas_pkg::REMOTE1_ACOUSTICS_CTRL_OFFSET);
  assign hit_second = (reg_addr_i == fas_pkg::ACOUSTICS_CTRL_SECOND_OFFSET);

  // remote1_acoustics_ctrl storage
  always_ff @(posedge clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      ctrl <= fas_pkg::REMOTE1_ACOUSTICS_CTRL_RESET;
    end else if (ce_i) begin
      // software writes the whole byte at once
      if (wr_ok && hit_ctrl) begin
        ctrl <= reg_wdata_i;
      end
    end
  end

  // second acoustics register, stored only
  always_ff @(posedge clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      ctrl_second <= fas_pkg::ACOUSTICS_CTRL_SECOND_RESET;
    end else if (ce_i) begin
      // same lock as the first register
      if (wr_ok && hit_second) begin
        ctrl_second <= reg_wdata_i;
      end
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      reg_rdata_o <= fas_pkg::UNMAPPED_READ;
    end else if (ce_i) begin
      if (reg_rd_i) begin
        // read back works whether or not the lock is set
        case (reg_addr_i)
          fas_pkg::REMOTE1_ACOUSTICS_CTRL_OFFSET: reg_rdata_o <= ctrl;
          fas_pkg::ACOUSTICS_CTRL_SECOND_OFFSET: reg_rdata_o <= ctrl_second;
          // unmapped addresses read as zero
          default: reg_rdata_o <= fas_pkg::UNMAPPED_READ;
        endcase
      end else begin
        // data bus idles at zero outside a read answer
        reg_rdata_o <= fas_pkg::UNMAPPED_READ;
      end
    end
  end

  // slot length from rate code and timing select
  always_comb begin
    if (ramp_timing_sel_i) begin
      slot_limit = SLOT_CYC_HF[ctrl.remote1_ramp_rate];
    end else begin
      slot_limit = SLOT_CYC_LF[ctrl.remote1_ramp_rate];
    end
  end

  // duty step for the current rate code
  assign ramp_inc = ramp_step(ctrl.remote1_ramp_rate);

  // slot end marker, one cycle wide
  assign slot_tick = (slot_cnt + 32'h1 >= slot_limit);

  // free-running slot timer, restarts at each slot end
  always_ff @(posedge clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      slot_cnt <= fas_pkg::SLOT_CNT_RESET;
    end else if (ce_i) begin
      // runs even with no drive smoothed, so a new ramp starts in step
      if (slot_tick) begin
        // also covers a shortened limit after a rate change
        slot_cnt <= 32'h0;
      end else begin
        slot_cnt <= slot_cnt + 32'h1;
      end
    end
  end

  // target duty with the below-start floor applied
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // default: the newly computed duty
      target[i] = drive_i[i].auto_duty;
      if (is_auto(drive_i[i].fan_behaviour_select) && drive_i[i].below_start) begin
        // floor choice per drive from bits 5..7
        if (ctrl.floor_select[i]) begin
          target[i] = drive_i[i].min_duty;
        end else begin
          target[i] = 8'h00;
        end
      end
    end
  end

  // a drive ramps only when remote 1 controls it and smoothing is on
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // behaviour code 000 ties the drive to remote 1
      smooth_on[i] = (drive_i[i].fan_behaviour_select == fas_pkg::BHV_REMOTE1)
                     && ctrl.remote1_smooth_enable;
    end
  end

  // duty outputs, ramped for remote-1 drives
  always_ff @(posedge clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      fan_drive_duty_o <= {3{fas_pkg::DUTY_RESET}};
    end else if (ce_i) begin
      for (int i = 0; i < 3; i++) begin
        if (smooth_on[i]) begin
          // gradual approach, one step per slot; holds between slots
          if (slot_tick) begin
            fan_drive_duty_o[i] <= step_toward(fan_drive_duty_o[i], target[i],
                                               ramp_inc);
          end
        end else begin
          // no smoothing: follow target at once
          fan_drive_duty_o[i] <= target[i];
        end
      end
    end
  end

  // speed inputs 2,3,4 measured in step with drive 3
  always_ff @(posedge clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      tach_sync_o <= fas_pkg::TACH_SYNC_RESET;
    end else if (ce_i) begin
      // inputs 3 and 4 always synced, input 2 by bit 4
      tach_sync_o <= {1'b1, 1'b1, ctrl.tach_sync};
    end
  end

endmodule
